// ### core/ops_params.svh
/*
 * Register offsets, field positions, reset values and timing constants of the
 * optical phase sequencer.
 * Assumes a single 50 MHz core clock; included by bare name from core/.
 */
`ifndef OPS_PARAMS_SVH
`define OPS_PARAMS_SVH

// ****************************************
// register map
// ****************************************
`define OPS_ADDR_W            8
`define OPS_REG_W             24
`define OPS_ADDR_AMP_FB       8'h21
`define OPS_ADDR_EMIT_CUR     8'h22
`define OPS_RST_AMP_FB        24'h000000
`define OPS_RST_EMIT_CUR      24'h000000

// ****************************************
// field layout
// ****************************************
`define OPS_GAIN_W            3
`define OPS_CODE_W            6
`define OPS_FB_GAIN1_LSB      0
`define OPS_FB_CAP1_LSB       3
`define OPS_FB_GAIN2_LSB      6
`define OPS_FB_CAP2_LSB       9
`define OPS_FB_SPLIT_BIT      15
`define OPS_EC_CODE1_LSB      0
`define OPS_EC_CODE2_LSB      6
`define OPS_EC_CODE3_LSB      12
`define OPS_EC_DOUBLE_BIT     18

// ****************************************
// drive current steps in microamps
// ****************************************
`define OPS_CUR_W             17
`define OPS_STEP_UA           17'h0031a
`define OPS_STEP2X_UA         17'h00633

// ****************************************
// timing
// ****************************************
`define OPS_CLK_MHZ           50
`define OPS_PRF_PERIOD_US     10000
`define OPS_SAMPLE_US         100
`define OPS_CONVRST_US        2
`define OPS_CYC(us)           ((us) * `OPS_CLK_MHZ)

// phases that take the second gain/capacitance set when split is on
`define OPS_SET_TWO_MAP       4'h5

`endif

// ### core/ops_phase_timer.sv
/*
 * Phase timer: runs one pulse repetition cycle of four phases, each a
 * sampling interval followed by a conversion reset interval, then idles.
 * Assumes a free running clock; ce_in low freezes every flop.
 */
`timescale 1ns/1ps
`include "ops_params.svh"

module ops_phase_timer #(
	parameter int CNT_W      = 24,
	parameter int PERIOD_CYC = `OPS_CYC(`OPS_PRF_PERIOD_US),
	parameter int SAMPLE_CYC = `OPS_CYC(`OPS_SAMPLE_US),
	parameter int CONV_CYC   = `OPS_CYC(`OPS_CONVRST_US)
) (
	input  wire logic              clk_in,
	input  wire logic              rst_b_in,
	input  wire logic              ce_in,
	output ops_pkg::ops_phase_t    phase_out,
	output logic                   sample_on_out,
	output logic                   conv_on_out,
	output logic                   conv_done_out,
	output logic                   cycle_start_out
);

	if (4 * (SAMPLE_CYC + CONV_CYC) >= PERIOD_CYC || SAMPLE_CYC < 1 || CONV_CYC < 1 ||
		PERIOD_CYC >= (1 << CNT_W)) begin : g_bad
		$error("ops_phase_timer: timing parameters do not fit");
	end

	ops_pkg::ops_state_t state;
	ops_pkg::ops_state_t next_state;
	logic [CNT_W-1:0]    period_cnt;
	logic [CNT_W-1:0]    tcnt;
	ops_pkg::ops_phase_t phase;

	wire period_wrap = (period_cnt == CNT_W'(PERIOD_CYC - 1));
	wire sample_end  = (tcnt == CNT_W'(SAMPLE_CYC - 1));
	wire conv_end    = (tcnt == CNT_W'(CONV_CYC - 1));

	always_comb begin
		next_state = state;
		unique case (state)
			ops_pkg::ST_GAP:    if (period_wrap) next_state = ops_pkg::ST_SAMPLE;
			ops_pkg::ST_SAMPLE: if (sample_end) next_state = ops_pkg::ST_CONV;
			ops_pkg::ST_CONV: begin
				if (conv_end) next_state = (phase == 2'h3) ? ops_pkg::ST_GAP : ops_pkg::ST_SAMPLE;
			end
			default:            next_state = ops_pkg::ST_GAP;
		endcase
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state      <= ops_pkg::ST_GAP;
			period_cnt <= '0;
			tcnt       <= '0;
			phase      <= 2'h0;
		end else if (ce_in) begin
			state      <= next_state;
			period_cnt <= period_wrap ? '0 : period_cnt + 1'b1;
			tcnt       <= (next_state != state) ? '0 : tcnt + 1'b1;
			if (state == ops_pkg::ST_GAP) phase <= 2'h0;
			else if (state == ops_pkg::ST_CONV && conv_end) phase <= phase + 2'h1;
		end
	end

	assign phase_out       = phase;
	assign sample_on_out   = (state == ops_pkg::ST_SAMPLE);
	assign conv_on_out     = (state == ops_pkg::ST_CONV);
	assign conv_done_out   = ce_in && (state == ops_pkg::ST_CONV) && conv_end;
	assign cycle_start_out = ce_in && (state == ops_pkg::ST_GAP) && period_wrap;

endmodule : ops_phase_timer

// ### core/ops_pkg.sv
/*
 * Types shared by the optical phase sequencer modules.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package ops_pkg;

	typedef enum logic [2:0] {
		ST_GAP    = 3'h1,
		ST_SAMPLE = 3'h2,
		ST_CONV   = 3'h4
	} ops_state_t;

	typedef logic [1:0] ops_phase_t;

endpackage : ops_pkg

// ### core/ops_sequencer.sv
/*
 * Optical phase sequencer: orders four sampling phases per pulse repetition
 * cycle, pulses emitters, routes the amplifier to filter slots, applies gain,
 * capacitance and drive settings, and stores four samples per cycle.
 * Assumes the converter result is on the same clock and valid at the end of
 * each conversion reset interval; mode pin is asynchronous.
 */
`timescale 1ns/1ps
`include "ops_params.svh"

// Contract
// - four 24-bit samples per cycle, separate registers
// - one of four filter slots per phase
// - combined conversion reset is union of four
// - two-emitter order: two, ambient, one, ambient
// - three-emitter order: two, three, one, ambient
// - two gain/capacitance sets, fixed phase assignment
// - independent 6-bit drive code per emitter
// - normal range: about 0.8 mA per step
// - doubled range: about 1.6 mA per step
// - split off: gain set one everywhere
// - split on: gain set two on two phases
// - each gain set is a 3-bit field
// - split off: capacitance set one everywhere
// - split on: capacitance follows gain assignment
module ops_sequencer #(
	parameter int PERIOD_CYC = `OPS_CYC(`OPS_PRF_PERIOD_US),
	parameter int SAMPLE_CYC = `OPS_CYC(`OPS_SAMPLE_US),
	parameter int CONV_CYC   = `OPS_CYC(`OPS_CONVRST_US)
) (
	input  wire logic                    MCLK_IN,
	input  wire logic                    RST_B_IN,
	input  wire logic                    CE_IN,
	input  wire logic                    THREE_EMITTER_MODE_IN,
	input  wire logic                    REG_WR_IN,
	input  wire logic                    REG_RD_IN,
	input  wire logic [`OPS_ADDR_W-1:0]  REG_ADDR_IN,
	input  wire logic [`OPS_REG_W-1:0]   REG_WDATA_IN,
	output logic      [`OPS_REG_W-1:0]   REG_RDATA_OUT,
	input  wire logic [`OPS_REG_W-1:0]   SAMPLE_DATA_IN,
	output logic      [`OPS_REG_W-1:0]   RESULT0_OUT,
	output logic      [`OPS_REG_W-1:0]   RESULT1_OUT,
	output logic      [`OPS_REG_W-1:0]   RESULT2_OUT,
	output logic      [`OPS_REG_W-1:0]   RESULT3_OUT,
	output logic                         EMITTER_ONE_OUT,
	output logic                         EMITTER_TWO_OUT,
	output logic                         EMITTER_THREE_OUT,
	output logic      [`OPS_CUR_W-1:0]   EMITTER_CURRENT_UA_OUT,
	output logic      [3:0]              FILTER_SEL_OUT,
	output logic      [3:0]              CONV_RESET_PHASE_OUT,
	output logic                         CONV_RESET_OUT,
	output logic      [`OPS_GAIN_W-1:0]  GAIN_OUT,
	output logic      [`OPS_GAIN_W-1:0]  CAP_OUT
);

	// ****************************************
	// functions
	// ****************************************
	function automatic logic [2:0] emit_sel(input logic [1:0] ph, input logic three);
		// bits {three, two, one}; slots 1 and 3 are ambient in two-emitter mode
		unique case (ph)
			2'h0: emit_sel = 3'h2;
			2'h1: emit_sel = three ? 3'h4 : 3'h0;
			2'h2: emit_sel = 3'h1;
			2'h3: emit_sel = 3'h0;
		endcase
	endfunction : emit_sel

	function automatic logic [`OPS_CUR_W-1:0] current_ua(input logic [`OPS_CODE_W-1:0] code,
		input logic dbl);
		logic [`OPS_CUR_W-1:0] step;
		step = dbl ? `OPS_STEP2X_UA : `OPS_STEP_UA;
		current_ua = `OPS_CUR_W'(code * step);
	endfunction : current_ua

	// ****************************************
	// registers and mode pin
	// ****************************************
	logic [`OPS_REG_W-1:0] amp_feedback_config;
	logic [`OPS_REG_W-1:0] emitter_current_config;
	logic                  mode_meta;
	logic                  mode_sync;
	logic                  three_mode;

	wire sel_amp = (REG_ADDR_IN == `OPS_ADDR_AMP_FB);
	wire sel_cur = (REG_ADDR_IN == `OPS_ADDR_EMIT_CUR);
	wire [`OPS_REG_W-1:0] rd_mux = sel_amp ? amp_feedback_config :
		sel_cur ? emitter_current_config : '0;

	always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			amp_feedback_config    <= `OPS_RST_AMP_FB;
			emitter_current_config <= `OPS_RST_EMIT_CUR;
			REG_RDATA_OUT          <= '0;
		end else if (CE_IN) begin
			if (REG_WR_IN && sel_amp) amp_feedback_config <= REG_WDATA_IN;
			if (REG_WR_IN && sel_cur) emitter_current_config <= REG_WDATA_IN;
			if (REG_RD_IN) REG_RDATA_OUT <= rd_mux;
		end
	end

	wire                    split_gain_enable    = amp_feedback_config[`OPS_FB_SPLIT_BIT];
	wire [`OPS_GAIN_W-1:0]  gain_set_one         = amp_feedback_config[`OPS_FB_GAIN1_LSB +: `OPS_GAIN_W];
	wire [`OPS_GAIN_W-1:0]  gain_set_two         = amp_feedback_config[`OPS_FB_GAIN2_LSB +: `OPS_GAIN_W];
	wire [`OPS_GAIN_W-1:0]  feedback_cap_set_one = amp_feedback_config[`OPS_FB_CAP1_LSB +: `OPS_GAIN_W];
	wire [`OPS_GAIN_W-1:0]  feedback_cap_set_two = amp_feedback_config[`OPS_FB_CAP2_LSB +: `OPS_GAIN_W];
	wire [`OPS_CODE_W-1:0]  code_one  = emitter_current_config[`OPS_EC_CODE1_LSB +: `OPS_CODE_W];
	wire [`OPS_CODE_W-1:0]  code_two  = emitter_current_config[`OPS_EC_CODE2_LSB +: `OPS_CODE_W];
	wire [`OPS_CODE_W-1:0]  code_three = emitter_current_config[`OPS_EC_CODE3_LSB +: `OPS_CODE_W];
	wire                    drive_range_double = emitter_current_config[`OPS_EC_DOUBLE_BIT];

	// ****************************************
	// phase timing
	// ****************************************
	ops_pkg::ops_phase_t phase;
	logic                sample_on;
	logic                conv_on;
	logic                conv_done;
	logic                cycle_start;

	ops_phase_timer #(
		.PERIOD_CYC (PERIOD_CYC),
		.SAMPLE_CYC (SAMPLE_CYC),
		.CONV_CYC   (CONV_CYC)
	) u_timer (
		.clk_in          (MCLK_IN),
		.rst_b_in        (RST_B_IN),
		.ce_in           (CE_IN),
		.phase_out       (phase),
		.sample_on_out   (sample_on),
		.conv_on_out     (conv_on),
		.conv_done_out   (conv_done),
		.cycle_start_out (cycle_start)
	);

	// mode is taken only at cycle start so a cycle never mixes orders
	always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			mode_meta  <= 1'b0;
			mode_sync  <= 1'b0;
			three_mode <= 1'b0;
		end else if (CE_IN) begin
			mode_meta <= THREE_EMITTER_MODE_IN;
			mode_sync <= mode_meta;
			if (cycle_start) three_mode <= mode_sync;
		end
	end

	// ****************************************
	// per-phase selection
	// ****************************************
	localparam logic [3:0] SET_TWO_MAP = `OPS_SET_TWO_MAP;

	wire        use_set_two = split_gain_enable && SET_TWO_MAP[phase];
	wire [2:0]  emit_now    = sample_on ? emit_sel(phase, three_mode) : 3'h0;
	wire [3:0]  phase_hot   = 4'h1 << phase;
	wire [`OPS_CODE_W-1:0] code_now = emit_now[0] ? code_one : emit_now[1] ? code_two :
		emit_now[2] ? code_three : '0;
	wire [`OPS_GAIN_W-1:0] next_gain = use_set_two ? gain_set_two : gain_set_one;
	wire [`OPS_GAIN_W-1:0] next_cap  = use_set_two ? feedback_cap_set_two : feedback_cap_set_one;

	logic [`OPS_REG_W-1:0] result [0:3];

	always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			{EMITTER_THREE_OUT, EMITTER_TWO_OUT, EMITTER_ONE_OUT} <= 3'h0;
			EMITTER_CURRENT_UA_OUT <= '0;
			FILTER_SEL_OUT         <= 4'h0;
			CONV_RESET_PHASE_OUT   <= 4'h0;
			GAIN_OUT               <= '0;
			CAP_OUT                <= '0;
			for (int i = 0; i < 4; i++) result[i] <= '0;
		end else if (CE_IN) begin
			{EMITTER_THREE_OUT, EMITTER_TWO_OUT, EMITTER_ONE_OUT} <= emit_now;
			EMITTER_CURRENT_UA_OUT <= current_ua(code_now, drive_range_double);
			FILTER_SEL_OUT         <= sample_on ? phase_hot : 4'h0;
			CONV_RESET_PHASE_OUT   <= conv_on ? phase_hot : 4'h0;
			GAIN_OUT               <= next_gain;
			CAP_OUT                <= next_cap;
			if (conv_done) result[phase] <= SAMPLE_DATA_IN;
		end
	end

	assign CONV_RESET_OUT = |CONV_RESET_PHASE_OUT;
	assign RESULT0_OUT    = result[0];
	assign RESULT1_OUT    = result[1];
	assign RESULT2_OUT    = result[2];
	assign RESULT3_OUT    = result[3];

	// ****************************************
	// assertions
	// ****************************************
	property p_result_store;
		@(posedge MCLK_IN) disable iff (!RST_B_IN)
		conv_done |=> result[$past(phase)] == $past(SAMPLE_DATA_IN);
	endproperty
	a_result_store: assert property (p_result_store) else $error("sample not stored in its slot");

	property p_filter_slot;
		@(posedge MCLK_IN) disable iff (!RST_B_IN)
		(CE_IN && sample_on) |=> $onehot(FILTER_SEL_OUT) && FILTER_SEL_OUT == (4'h1 << $past(phase));
	endproperty
	a_filter_slot: assert property (p_filter_slot) else $error("wrong filter slot");

	property p_conv_union;
		@(posedge MCLK_IN) disable iff (!RST_B_IN)
		CE_IN |=> CONV_RESET_OUT == $past(conv_on) && $countones(CONV_RESET_PHASE_OUT) <= 1;
	endproperty
	a_conv_union: assert property (p_conv_union) else $error("combined conversion reset wrong");

	property p_two_mode_ambient;
		@(posedge MCLK_IN) disable iff (!RST_B_IN)
		(CE_IN && sample_on && !three_mode && phase[0])
			|=> !EMITTER_ONE_OUT && !EMITTER_TWO_OUT && !EMITTER_THREE_OUT;
	endproperty
	a_two_mode_ambient: assert property (p_two_mode_ambient) else $error("emitter lit in ambient");

	property p_three_mode_order;
		@(posedge MCLK_IN) disable iff (!RST_B_IN)
		(CE_IN && sample_on && three_mode) |=>
			(EMITTER_TWO_OUT == ($past(phase) == 2'h0)) && (EMITTER_THREE_OUT == ($past(phase) == 2'h1)) &&
			(EMITTER_ONE_OUT == ($past(phase) == 2'h2));
	endproperty
	a_three_mode_order: assert property (p_three_mode_order) else $error("three-emitter order wrong");

	property p_gain_select;
		@(posedge MCLK_IN) disable iff (!RST_B_IN)
		CE_IN |=> GAIN_OUT == (($past(split_gain_enable) && SET_TWO_MAP[$past(phase)]) ?
			$past(gain_set_two) : $past(gain_set_one));
	endproperty
	a_gain_select: assert property (p_gain_select) else $error("gain set mismatch");

	property p_cap_split_off;
		@(posedge MCLK_IN) disable iff (!RST_B_IN)
		(CE_IN && !split_gain_enable) |=> CAP_OUT == $past(feedback_cap_set_one);
	endproperty
	a_cap_split_off: assert property (p_cap_split_off) else $error("capacitance not set one");

	property p_drive_current;
		@(posedge MCLK_IN) disable iff (!RST_B_IN)
		(CE_IN && sample_on && phase == 2'h2) |=> EMITTER_CURRENT_UA_OUT ==
			`OPS_CUR_W'($past(code_one) * ($past(drive_range_double) ? `OPS_STEP2X_UA : `OPS_STEP_UA));
	endproperty
	a_drive_current: assert property (p_drive_current) else $error("emitter one current wrong");

	property p_mode_hold;
		@(posedge MCLK_IN) disable iff (!RST_B_IN)
		!cycle_start |=> $stable(three_mode);
	endproperty
	a_mode_hold: assert property (p_mode_hold) else $error("mode changed mid cycle");

	c_three_cycle: cover property (@(posedge MCLK_IN) disable iff (!RST_B_IN) EMITTER_THREE_OUT);
	c_split_gain: cover property (@(posedge MCLK_IN) disable iff (!RST_B_IN)
		split_gain_enable && use_set_two && sample_on);
	c_all_stored: cover property (@(posedge MCLK_IN) disable iff (!RST_B_IN) conv_done && phase == 2'h3);

endmodule : ops_sequencer

// ### sim/ops_photo_model.sv
/*
 * Photodiode and converter model on the far side of the sequencer: sees the
 * emitter pulses and hands back one result word per conversion interval.
 * Assumes the sequencer's clock; the word is only meaningful while converting.
 */
`timescale 1ns/1ps

module ops_photo_model (
	input  wire logic        clk_in,
	input  wire logic        emit_one_in,
	input  wire logic        emit_two_in,
	input  wire logic        emit_three_in,
	input  wire logic [3:0]  conv_phase_in,
	output logic      [23:0] sample_out
);
	logic [3:0] seen   = 4'h0;
	logic       conv_d = 1'b0;
	logic [7:0] churn  = 8'h00;

	// remembers which light fell on the diode in the latest sampling interval
	always @(posedge clk_in) begin
		churn  <= churn + 8'h01;
		conv_d <= |conv_phase_in;
		if (emit_one_in) begin
			seen <= 4'h1;
		end else if (emit_two_in) begin
			seen <= 4'h2;
		end else if (emit_three_in) begin
			seen <= 4'h3;
		end else if (conv_d && !(|conv_phase_in)) begin
			seen <= 4'h0;
		end
	end

	// outside conversion the word churns so a capture at the wrong moment shows
	always_comb begin
		if (|conv_phase_in) begin
			sample_out = {12'h0a5, seen, 4'h0, conv_phase_in};
		end else begin
			sample_out = ~{12'h0a5, seen, 4'h0, conv_phase_in} ^ {16'h0000, churn};
		end
	end
endmodule : ops_photo_model

// ### sim/ops_sequencer_tb.sv
/*
 * Self-checking bench for the optical phase sequencer with a photodiode model.
 * Assumes short timer parameters (64/6/2) and inputs driven on falling edges.
 */
`timescale 1ns/1ps
`include "ops_params.svh"

module ops_sequencer_tb;
	typedef struct packed {
		logic        mode;
		logic [23:0] fb;
		logic [23:0] ec;
		logic [7:0]  ids;
	} ops_row_t;

	logic        MCLK_IN = 1'b0;
	logic        RST_B_IN, CE_IN, THREE_EMITTER_MODE_IN, REG_WR_IN, REG_RD_IN;
	logic [7:0]  REG_ADDR_IN;
	logic [23:0] REG_WDATA_IN, REG_RDATA_OUT, SAMPLE_DATA_IN;
	logic [23:0] RESULT0_OUT, RESULT1_OUT, RESULT2_OUT, RESULT3_OUT;
	logic        EMITTER_ONE_OUT, EMITTER_TWO_OUT, EMITTER_THREE_OUT, CONV_RESET_OUT;
	logic [16:0] EMITTER_CURRENT_UA_OUT;
	logic [3:0]  FILTER_SEL_OUT, CONV_RESET_PHASE_OUT;
	logic [2:0]  GAIN_OUT, CAP_OUT;
	ops_row_t    rows [4];
	int          fails = 0;
	int          n_tests = 0;

	always #10 MCLK_IN = ~MCLK_IN;

	ops_sequencer #(.PERIOD_CYC(64), .SAMPLE_CYC(6), .CONV_CYC(2)) i_dut (.MCLK_IN(MCLK_IN), .RST_B_IN(RST_B_IN),
		.CE_IN(CE_IN), .THREE_EMITTER_MODE_IN(THREE_EMITTER_MODE_IN), .REG_WR_IN(REG_WR_IN), .REG_RD_IN(REG_RD_IN),
		.REG_ADDR_IN(REG_ADDR_IN), .REG_WDATA_IN(REG_WDATA_IN), .REG_RDATA_OUT(REG_RDATA_OUT),
		.SAMPLE_DATA_IN(SAMPLE_DATA_IN), .RESULT0_OUT(RESULT0_OUT), .RESULT1_OUT(RESULT1_OUT),
		.RESULT2_OUT(RESULT2_OUT), .RESULT3_OUT(RESULT3_OUT), .EMITTER_ONE_OUT(EMITTER_ONE_OUT),
		.EMITTER_TWO_OUT(EMITTER_TWO_OUT), .EMITTER_THREE_OUT(EMITTER_THREE_OUT),
		.EMITTER_CURRENT_UA_OUT(EMITTER_CURRENT_UA_OUT), .FILTER_SEL_OUT(FILTER_SEL_OUT),
		.CONV_RESET_PHASE_OUT(CONV_RESET_PHASE_OUT), .CONV_RESET_OUT(CONV_RESET_OUT), .GAIN_OUT(GAIN_OUT),
		.CAP_OUT(CAP_OUT));

	ops_photo_model i_photo (.clk_in(MCLK_IN), .emit_one_in(EMITTER_ONE_OUT), .emit_two_in(EMITTER_TWO_OUT),
		.emit_three_in(EMITTER_THREE_OUT), .conv_phase_in(CONV_RESET_PHASE_OUT), .sample_out(SAMPLE_DATA_IN));

	// ****************************************
	// tasks
	// ****************************************
	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : end_sim

	task automatic chk_word(input string what, input logic [23:0] exp, input logic [23:0] got);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("Error: %s expected %h seen %h", what, exp, got);
		end
	endtask : chk_word

	task automatic chk_flag(input string what, input logic [3:0] exp, input logic [3:0] got);
		chk_word(what, {20'h0, exp}, {20'h0, got});
	endtask : chk_flag

	function automatic logic [23:0] res(input int p);
		case (p)
			0: return RESULT0_OUT;
			1: return RESULT1_OUT;
			2: return RESULT2_OUT;
			default: return RESULT3_OUT;
		endcase
	endfunction : res

	// bounded wait on the filter select (sel high) or the per-phase conversion resets
	task automatic wait_for(input logic [3:0] want, input logic sel);
		int k;
		k = 0;
		while (((sel ? FILTER_SEL_OUT : CONV_RESET_PHASE_OUT) !== want) && k < 200) begin
			@(negedge MCLK_IN);
			k++;
		end
		if (k >= 200) begin
			fails++;
			$display("Error: wait expected %h, timed out", want);
			end_sim();
		end
	endtask : wait_for

	task automatic wr_reg(input logic [7:0] a, input logic [23:0] d);
		REG_ADDR_IN = a;
		REG_WDATA_IN = d;
		REG_WR_IN = 1'b1;
		@(negedge MCLK_IN);
		REG_WR_IN = 1'b0;
		// one idle edge so a following write never re-raises the strobe in the same step
		@(negedge MCLK_IN);
	endtask : wr_reg

	task automatic rd_reg(input logic [7:0] a, input logic [23:0] exp);
		REG_ADDR_IN = a;
		REG_RD_IN = 1'b1;
		@(negedge MCLK_IN);
		REG_RD_IN = 1'b0;
		@(negedge MCLK_IN);
		chk_word("read data", exp, REG_RDATA_OUT);
	endtask : rd_reg

	// checks one whole cycle; the mode pin is flipped early in phase 0
	task automatic run_cycle(input ops_row_t r, input logic next_mode);
		logic [3:0]  map;
		logic [3:0]  oh;
		logic [1:0]  id;
		logic [5:0]  code;
		logic [16:0] step;
		logic        two;
		logic [23:0] smp [4];
		map = `OPS_SET_TWO_MAP;
		step = r.ec[`OPS_EC_DOUBLE_BIT] ? `OPS_STEP2X_UA : `OPS_STEP_UA;
		for (int p = 0; p < 4; p++) begin
			oh = 4'h1 << p;
			id = r.ids[2*p +: 2];
			two = r.fb[`OPS_FB_SPLIT_BIT] & map[p];
			code = (id == 2'h1) ? r.ec[`OPS_EC_CODE1_LSB +: `OPS_CODE_W] :
				(id == 2'h2) ? r.ec[`OPS_EC_CODE2_LSB +: `OPS_CODE_W] :
				(id == 2'h3) ? r.ec[`OPS_EC_CODE3_LSB +: `OPS_CODE_W] : 6'h00;
			smp[p] = {12'h0a5, 2'h0, id, 4'h0, oh};
			wait_for(oh, 1'b1);
			chk_flag("emitters", {1'b0, id == 2'h3, id == 2'h2, id == 2'h1},
				{1'b0, EMITTER_THREE_OUT, EMITTER_TWO_OUT, EMITTER_ONE_OUT});
			chk_flag("gain", {1'b0, two ? r.fb[`OPS_FB_GAIN2_LSB +: 3] : r.fb[`OPS_FB_GAIN1_LSB +: 3]},
				{1'b0, GAIN_OUT});
			chk_flag("cap", {1'b0, two ? r.fb[`OPS_FB_CAP2_LSB +: 3] : r.fb[`OPS_FB_CAP1_LSB +: 3]},
				{1'b0, CAP_OUT});
			chk_word("current", {7'h0, {11'h0, code} * step}, {7'h0, EMITTER_CURRENT_UA_OUT});
			chk_flag("conv in sample", 4'h0, {3'h0, CONV_RESET_OUT});
			chk_flag("conv phase in sample", 4'h0, CONV_RESET_PHASE_OUT);
			if (p == 0) begin
				THREE_EMITTER_MODE_IN = next_mode;
			end
			wait_for(oh, 1'b0);
			chk_flag("filter in conv", 4'h0, FILTER_SEL_OUT);
			chk_flag("emitters in conv", 4'h0,
				{1'b0, EMITTER_THREE_OUT, EMITTER_TWO_OUT, EMITTER_ONE_OUT});
			chk_flag("conv union", 4'h1, {3'h0, CONV_RESET_OUT});
			wait_for(4'h0, 1'b0);
			chk_word("result", smp[p], res(p));
		end
		for (int p = 0; p < 4; p++) begin
			chk_word("result held", smp[p], res(p));
		end
	endtask : run_cycle

	// ****************************************
	// sequence
	// ****************************************
	initial begin
		RST_B_IN = 1'b0;
		CE_IN = 1'b1;
		THREE_EMITTER_MODE_IN = 1'b0;
		REG_WR_IN = 1'b0;
		REG_RD_IN = 1'b0;
		REG_ADDR_IN = 8'h00;
		REG_WDATA_IN = 24'h000000;
		// gain and capacitance codes stand for small time constants against the pulse
		rows[0] = '{1'b0, 24'h000c55, 24'h02a07f, 8'h12};
		rows[1] = '{1'b1, 24'h008687, 24'h07f540, 8'h1e};
		rows[2] = '{1'b0, 24'h008b38, 24'h041fe0, 8'h12};
		rows[3] = '{1'b1, 24'h0003a3, 24'h015a81, 8'h1e};
		repeat (16) @(negedge MCLK_IN);
		RST_B_IN = 1'b1;
		rd_reg(`OPS_ADDR_AMP_FB, `OPS_RST_AMP_FB);
		rd_reg(`OPS_ADDR_EMIT_CUR, `OPS_RST_EMIT_CUR);
		$display("test reset values done");
		foreach (rows[i]) begin
			THREE_EMITTER_MODE_IN = rows[i].mode;
			wr_reg(`OPS_ADDR_AMP_FB, rows[i].fb);
			wr_reg(`OPS_ADDR_EMIT_CUR, rows[i].ec);
			rd_reg(`OPS_ADDR_AMP_FB, rows[i].fb);
			rd_reg(`OPS_ADDR_EMIT_CUR, rows[i].ec);
			run_cycle(rows[i], rows[i].mode);
			$display("test row %0d done", i);
		end
		// mode flipped mid-cycle must wait for the next cycle
		run_cycle(rows[3], 1'b0);
		run_cycle('{1'b0, rows[3].fb, rows[3].ec, 8'h12}, 1'b0);
		$display("test mode change done");
		wr_reg(8'h30, 24'hffffff);
		rd_reg(8'h30, 24'h000000);
		CE_IN = 1'b0;
		wr_reg(`OPS_ADDR_AMP_FB, 24'h00ffff);
		CE_IN = 1'b1;
		rd_reg(`OPS_ADDR_AMP_FB, rows[3].fb);
		$display("test unmapped and enable done");
		wait_for(4'h2, 1'b1);
		RST_B_IN = 1'b0;
		@(negedge MCLK_IN);
		chk_flag("filter in reset", 4'h0, FILTER_SEL_OUT);
		chk_word("result in reset", 24'h000000, RESULT0_OUT);
		RST_B_IN = 1'b1;
		rd_reg(`OPS_ADDR_AMP_FB, `OPS_RST_AMP_FB);
		wr_reg(`OPS_ADDR_AMP_FB, rows[0].fb);
		wr_reg(`OPS_ADDR_EMIT_CUR, rows[0].ec);
		run_cycle(rows[0], 1'b0);
		$display("test second reset done");
		end_sim();
	end
endmodule : ops_sequencer_tb
